// *** asp_pkg.sv ***
// shared constants and carrier types for the audio serial port setup block
package asp_pkg;

   // register byte offsets on the avalon-mm slave
   localparam logic [7:0] ASP_SETUP_OFS  = 8'h0C;
   localparam logic [7:0] ASP_CLKDIV_OFS = 8'h10;
   localparam logic [7:0] ASP_FRAME_OFS  = 8'h20;
   localparam logic [7:0] ASP_TXDATA_OFS = 8'h24;
   localparam logic [7:0] ASP_RXDATA_OFS = 8'h28;
   localparam logic [7:0] ASP_STATUS_OFS = 8'h2C;

   // widths
   localparam int ASP_ADDR_W = 8;
   localparam int ASP_CFG_W  = 14;
   localparam int ASP_WORD_W = 16;
   localparam int ASP_DEPTH  = 8;
   localparam int ASP_LVL_W  = 4;

   // reset values
   localparam logic [13:0] ASP_CFG_RST    = 14'h0000;
   localparam logic [31:0] ASP_CLKDIV_RST = 32'h0000_0000;
   localparam logic [7:0]  ASP_FRAME_RST  = 8'h00;

   // status field positions
   localparam int ASP_ST_TXLVL_LSB = 0;
   localparam int ASP_ST_RXLVL_LSB = 8;
   localparam int ASP_ST_OVR_BIT   = 16;

   // setup register fields, msb first (bit 13 down to bit 0)
   typedef struct packed {
      logic common_sync; // 13
      logic rx_bclk_sep; // 12
      logic fsx_pol;     // 11
      logic fsr_pol;     // 10
      logic clkx_edge;   // 9
      logic clkr_edge;   // 8
      logic fsx_src;     // 7
      logic fsr_src;     // 6
      logic clkx_src;    // 5
      logic clkr_src;    // 4
      logic ena_tx;      // 3
      logic ena_rx;      // 2
      logic tx_stereo;   // 1
      logic mode_ac97;   // 0
   } asp_cfg_s;

   // levels arriving from the codec pins
   typedef struct packed {
      logic bclk_x;
      logic bclk_r;
      logic fs_x;
      logic fs_r;
      logic rxd;
   } asp_pin_in_s;

   // levels and output enables toward the codec pins
   typedef struct packed {
      logic bclk_x;
      logic bclk_x_oe;
      logic bclk_r;
      logic bclk_r_oe;
      logic fs_x;
      logic fs_x_oe;
      logic fs_r;
      logic fs_r_oe;
      logic txd;
      logic txd_oe;
   } asp_pin_out_s;

endpackage

// *** asp_fifo.sv ***
// word fifo with valid/ready on both sides
`timescale 1ns/1ps
module asp_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic                       clk_in,
   input  wire logic                       reset_n_in,
   // fill side
   input  wire logic                       in_valid_in,
   output logic                            in_ready_out,
   input  wire logic [WIDTH-1:0]           in_data_in,
   // drain side
   output logic                            out_valid_out,
   input  wire logic                       out_ready_in,
   output logic [WIDTH-1:0]                out_data_out,
   // fill level
   output logic [$clog2(DEPTH):0]          level_out
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;

   // occupancy and handshakes
   wire [AW:0] count = wr_ptr - rd_ptr;
   wire        push  = in_valid_in & (count != FULL_CNT);
   wire        pop   = out_ready_in & (count != '0);

   assign in_ready_out  = (count != FULL_CNT);
   assign out_valid_out = (count != '0);
   assign out_data_out  = mem[rd_ptr[AW-1:0]];
   assign level_out     = count;

   // storage, no reset needed
   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data_in;
      end
   end

   // pointers
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) wr_ptr <= wr_ptr + 1'b1;
         if (pop) rd_ptr <= rd_ptr + 1'b1;
      end
   end
endmodule

// *** asp_setup.sv ***
// audio serial port: setup register, clock/sync generation and datapaths
// How it works
// - bit 12 clear: receive runs on transmit bit clock; set: own receive bit clock.
// - a shared bit clock is always the transmit bit clock.
// - bit 11 sets transmit sync polarity: internal active low, external inverted.
// - bit 10 sets receive sync polarity: internal active low, external inverted.
// - bit 9 picks the bit clock edge that moves transmit data and sync.
// - bit 8 picks the edge that moves receive sync and samples data.
// - bits 7 and 6 enable the sync pads; clear means codec drives sync.
// - bits 5 and 4 enable the bit clock pads; clear means codec drives.
// - clocks and syncs run whatever the datapath enables say.
// - bit 3 clear keeps transmit data floating; set pops and serializes words.
// - bit 2 clear ignores receive data; set deserializes and pushes words.
// - bit 1 sends one channel per frame, or one per half frame.
// - stereo select only counts in i2s operation.
// - bit 0 picks i2s (clear) or ac97 (set) operation.
// - common sync makes receive use transmit sync and transmit bit clock.
//
// Implementation choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
module asp_setup
   import asp_pkg::*;
(
   // clock and reset
   input  wire logic                  core_clk_in,
   input  wire logic                  reset_n_in,
   // avalon-mm slave
   input  wire logic [ASP_ADDR_W-1:0] avs_address_in,
   input  wire logic                  avs_read_in,
   input  wire logic                  avs_write_in,
   input  wire logic [31:0]           avs_writedata_in,
   input  wire logic [3:0]            avs_byteenable_in,
   output logic [31:0]                avs_readdata_out,
   output logic                       avs_waitrequest_out,
   // codec pins
   input  wire asp_pin_in_s           pins_in,
   output asp_pin_out_s               pins_out
);

   // ---------------- registers and bus state ----------------
   asp_cfg_s           cfg;
   logic [31:0]        clkdiv;
   logic [7:0]         frame_bits;
   logic               overrun;
   logic               wait_q;
   logic [31:0]        rdata_q;
   logic               rd_vld_q;

   // fifo wiring
   logic               tx_in_ready;
   logic               tx_out_valid;
   logic               tx_out_ready;
   logic [15:0]        tx_out_data;
   logic [ASP_LVL_W-1:0] tx_lvl;
   logic               rx_in_ready;
   logic               rx_out_valid;
   logic               rx_out_ready;
   logic [15:0]        rx_out_data;
   logic [ASP_LVL_W-1:0] rx_lvl;
   logic               rx_push;
   logic [15:0]        rx_sh;

   // address decode
   wire sel_setup  = (avs_address_in == ASP_SETUP_OFS);
   wire sel_clkdiv = (avs_address_in == ASP_CLKDIV_OFS);
   wire sel_frame  = (avs_address_in == ASP_FRAME_OFS);
   wire sel_txdata = (avs_address_in == ASP_TXDATA_OFS);
   wire sel_rxdata = (avs_address_in == ASP_RXDATA_OFS);
   wire sel_status = (avs_address_in == ASP_STATUS_OFS);

   // handshake: one cycle to arm, completion on the edge with waitrequest low
   wire req        = avs_read_in | avs_write_in;
   wire tx_blocked = avs_write_in & sel_txdata & ~tx_in_ready; // fifo full stalls the master
   wire arm        = req & wait_q & ~tx_blocked;
   wire done       = ~wait_q;
   wire wr_done    = done & avs_write_in;
   wire rd_done    = done & avs_read_in;

   // byte-lane merge for writable registers
   wire [31:0] be_mask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                          {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
   wire [31:0] setup_rd   = {18'h00000, cfg};
   wire [31:0] frame_rd   = {24'h000000, frame_bits};
   wire [31:0] merge_set  = (setup_rd & ~be_mask) | (avs_writedata_in & be_mask);
   wire [31:0] merge_div  = (clkdiv & ~be_mask) | (avs_writedata_in & be_mask);
   wire [31:0] merge_frm  = (frame_rd & ~be_mask) | (avs_writedata_in & be_mask);
   wire [31:0] rx_rd      = rx_out_valid ? {16'h0000, rx_out_data} : 32'h0000_0000;
   wire [31:0] status_rd  = {15'h0000, overrun, 4'h0, rx_lvl, 4'h0, tx_lvl};

   // read data select, unmapped offsets read zero
   wire [31:0] rd_mux = sel_setup  ? setup_rd  :
                        sel_clkdiv ? clkdiv    :
                        sel_frame  ? frame_rd  :
                        sel_rxdata ? rx_rd     :
                        sel_status ? status_rd : 32'h0000_0000;

   // fifo strobes from the bus
   wire rx_ovf_evt = rx_push & ~rx_in_ready;
   assign rx_out_ready = rd_done & sel_rxdata & rd_vld_q;

   // bus answer: waitrequest drops for exactly one cycle per access
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         wait_q   <= 1'b1;
         rdata_q  <= 32'h0000_0000;
         rd_vld_q <= 1'b0;
      end else if (done) begin
         wait_q   <= 1'b1;
      end else if (arm) begin
         wait_q   <= 1'b0;
         rdata_q  <= avs_read_in ? rd_mux : 32'h0000_0000;
         rd_vld_q <= rx_out_valid;
      end
   end

   // software registers, written on the completion edge
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         cfg        <= asp_cfg_s'(ASP_CFG_RST);
         clkdiv     <= ASP_CLKDIV_RST;
         frame_bits <= ASP_FRAME_RST;
      end else if (wr_done) begin
         if (sel_setup) cfg <= asp_cfg_s'(merge_set[ASP_CFG_W-1:0]);
         if (sel_clkdiv) clkdiv <= merge_div;
         if (sel_frame) frame_bits <= merge_frm[7:0];
      end
   end

   // overrun sticky flag, a new event wins over a clear
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         overrun <= 1'b0;
      end else if (rx_ovf_evt) begin
         overrun <= 1'b1;
      end else if (wr_done & sel_status & avs_writedata_in[ASP_ST_OVR_BIT]) begin
         overrun <= 1'b0;
      end
   end

   // ---------------- pin synchroniser ----------------
   asp_pin_in_s pin_meta;
   asp_pin_in_s pin_sync;

   // two flops before any logic reads a pin
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         pin_meta <= '0;
         pin_sync <= '0;
      end else begin
         pin_meta <= pins_in;
         pin_sync <= pin_meta;
      end
   end

   // ---------------- per-direction clock and sync ----------------
   // index 0 is transmit, index 1 is receive
   wire [1:0]  clk_src  = {cfg.clkr_src, cfg.clkx_src};
   wire [1:0]  edge_pol = {cfg.clkr_edge, cfg.clkx_edge};
   wire [1:0]  fs_pol   = {cfg.fsr_pol, cfg.fsx_pol};
   wire [1:0]  fs_src   = {cfg.fsr_src, cfg.fsx_src};
   wire [1:0]  clk_pin  = {pin_sync.bclk_r, pin_sync.bclk_x};
   wire [1:0]  fs_pin   = {pin_sync.fs_r, pin_sync.fs_x};
   wire [7:0]  half     = {1'b0, frame_bits[7:1]};
   wire        ac97     = cfg.mode_ac97;
   wire        stereo   = cfg.tx_stereo & ~cfg.mode_ac97;
   wire        rx_share = ~cfg.rx_bclk_sep | cfg.common_sync;

   logic [1:0] gen_clk;
   logic [1:0] src_clk;
   logic [1:0] bclk;
   logic [1:0] act;
   logic [1:0] fs_raw;
   logic [1:0] fs_eff;
   logic [1:0] fs_pad;
   logic [1:0] start;
   logic [1:0] mid;

   // receive clock and sync may be taken from the transmit side
   assign bclk[0]   = src_clk[0];
   assign bclk[1]   = rx_share ? src_clk[0] : src_clk[1];
   assign fs_eff[0] = fs_raw[0];
   assign fs_eff[1] = cfg.common_sync ? fs_raw[0] : fs_raw[1];

   for (genvar d = 0; d < 2; d++) begin : g_dir
      logic [15:0] div_cnt;
      logic        gen_q;
      logic        bclk_q;
      logic        fs_q;
      logic [7:0]  fcnt;

      wire [15:0] div_val  = (d == 0) ? clkdiv[15:0] : clkdiv[31:16];
      wire        div_wrap = ({1'b0, div_cnt} + 17'h00001) >= {1'b0, div_val};
      wire        rise     = bclk[d] & ~bclk_q;
      wire        fall     = ~bclk[d] & bclk_q;
      wire        f_wrap   = ({1'b0, fcnt} + 9'h001) >= {1'b0, frame_bits};
      wire        fs_int   = ac97 ? (fcnt == 8'h00) : (fcnt < half);

      assign gen_clk[d] = gen_q;
      assign src_clk[d] = clk_src[d] ? gen_q : clk_pin[d];
      assign act[d]     = edge_pol[d] ? fall : rise;
      assign fs_pad[d]  = fs_int ^ fs_pol[d];
      assign fs_raw[d]  = fs_src[d] ? fs_int : (fs_pin[d] ^ fs_pol[d]);
      assign start[d]   = act[d] & fs_eff[d] & ~fs_q;
      assign mid[d]     = act[d] & ~fs_eff[d] & fs_q;

      // bit clock divider, free of the datapath enables
      always_ff @(posedge core_clk_in) begin
         if (!reset_n_in) begin
            div_cnt <= 16'h0000;
            gen_q   <= 1'b0;
         end else if (!clk_src[d]) begin
            div_cnt <= 16'h0000;
            gen_q   <= 1'b0;
         end else if (div_wrap) begin
            div_cnt <= 16'h0000;
            gen_q   <= ~gen_q;
         end else begin
            div_cnt <= div_cnt + 16'h0001;
         end
      end

      // edge detect, frame counter and sync history on the active edge
      always_ff @(posedge core_clk_in) begin
         if (!reset_n_in) begin
            bclk_q <= 1'b0;
            fs_q   <= 1'b0;
            fcnt   <= 8'h00;
         end else begin
            bclk_q <= bclk[d];
            if (act[d]) begin
               fs_q <= fs_eff[d];
               fcnt <= f_wrap ? 8'h00 : fcnt + 8'h01;
            end
         end
      end
   end

   // ---------------- transmit serializer ----------------
   logic [15:0] tx_sh;
   logic        tx_bit;

   wire        tx_load = start[0] | (stereo & mid[0]);
   wire [15:0] tx_word = tx_out_valid ? tx_out_data : 16'h0000;
   assign tx_out_ready = tx_load & cfg.ena_tx;

   // msb first, one bit per active transmit edge
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         tx_sh  <= 16'h0000;
         tx_bit <= 1'b0;
      end else if (!cfg.ena_tx) begin
         tx_sh  <= 16'h0000;
         tx_bit <= 1'b0;
      end else if (tx_load) begin
         tx_bit <= tx_word[15];
         tx_sh  <= {tx_word[14:0], 1'b0};
      end else if (act[0]) begin
         tx_bit <= tx_sh[15];
         tx_sh  <= {tx_sh[14:0], 1'b0};
      end
   end

   asp_fifo #(
      .WIDTH (ASP_WORD_W),
      .DEPTH (ASP_DEPTH)
   ) u_tx_fifo (
      .clk_in        (core_clk_in),
      .reset_n_in    (reset_n_in),
      .in_valid_in   (wr_done & sel_txdata),
      .in_ready_out  (tx_in_ready),
      .in_data_in    (avs_writedata_in[15:0]),
      .out_valid_out (tx_out_valid),
      .out_ready_in  (tx_out_ready),
      .out_data_out  (tx_out_data),
      .level_out     (tx_lvl)
   );

   // ---------------- receive deserializer ----------------
   logic [4:0] rx_cnt;

   wire       rx_run  = (rx_cnt != 5'h00) & (rx_cnt < 5'h10);
   wire       rx_take = act[1] & cfg.ena_rx & (start[1] | rx_run);
   wire [4:0] rx_next = start[1] ? 5'h01 : rx_cnt + 5'h01;

   // word complete after sixteen samples, pushed one cycle later
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         rx_sh   <= 16'h0000;
         rx_cnt  <= 5'h00;
         rx_push <= 1'b0;
      end else if (!cfg.ena_rx) begin
         rx_cnt  <= 5'h00;
         rx_push <= 1'b0;
      end else begin
         rx_push <= rx_take & (rx_next == 5'h10);
         if (rx_take) begin
            rx_sh  <= {rx_sh[14:0], pin_sync.rxd};
            rx_cnt <= rx_next;
         end
      end
   end

   asp_fifo #(
      .WIDTH (ASP_WORD_W),
      .DEPTH (ASP_DEPTH)
   ) u_rx_fifo (
      .clk_in        (core_clk_in),
      .reset_n_in    (reset_n_in),
      .in_valid_in   (rx_push),
      .in_ready_out  (rx_in_ready),
      .in_data_in    (rx_sh),
      .out_valid_out (rx_out_valid),
      .out_ready_in  (rx_out_ready),
      .out_data_out  (rx_out_data),
      .level_out     (rx_lvl)
   );

   // ---------------- pin outputs ----------------
   asp_pin_out_s next_pins;

   // pad levels and enables, all registered below
   always_comb begin
      next_pins.bclk_x    = gen_clk[0];
      next_pins.bclk_x_oe = cfg.clkx_src;
      next_pins.bclk_r    = gen_clk[1];
      next_pins.bclk_r_oe = cfg.clkr_src;
      next_pins.fs_x      = fs_pad[0];
      next_pins.fs_x_oe   = cfg.fsx_src;
      next_pins.fs_r      = fs_pad[1];
      next_pins.fs_r_oe   = cfg.fsr_src;
      next_pins.txd       = tx_bit;
      next_pins.txd_oe    = cfg.ena_tx;
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         pins_out <= '0;
      end else begin
         pins_out <= next_pins;
      end
   end

   assign avs_readdata_out    = rdata_q;
   assign avs_waitrequest_out = wait_q;

endmodule

// *** asp_sva.sv ***
// concurrent checks on the ports of the audio serial port setup block
`timescale 1ns/1ps
module asp_sva
   import asp_pkg::*;
(
   // clock and reset
   input wire logic                  core_clk_in,
   input wire logic                  reset_n_in,
   // register bus
   input wire logic [ASP_ADDR_W-1:0] avs_address_in,
   input wire logic                  avs_read_in,
   input wire logic                  avs_write_in,
   input wire logic [31:0]           avs_writedata_in,
   input wire logic [3:0]            avs_byteenable_in,
   input wire logic [31:0]           avs_readdata_out,
   input wire logic                  avs_waitrequest_out,
   // codec pins
   input wire asp_pin_in_s           pins_in,
   input wire asp_pin_out_s          pins_out
);
   asp_cfg_s   cfg;
   logic [3:0] age;
   // decode of completed accesses
   wire logic done   = !avs_waitrequest_out;
   wire logic wr_cfg = done && avs_write_in && avs_address_in == ASP_SETUP_OFS;
   wire logic mapped = avs_address_in inside {ASP_SETUP_OFS, ASP_CLKDIV_OFS, ASP_FRAME_OFS,
                                              ASP_TXDATA_OFS, ASP_RXDATA_OFS, ASP_STATUS_OFS};
   wire logic [13:0] next_cfg = {avs_byteenable_in[1] ? avs_writedata_in[13:8] : cfg[13:8],
                                 avs_byteenable_in[0] ? avs_writedata_in[7:0] : cfg[7:0]};
   // shadow of the setup register and cycles since it last changed
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         cfg <= '0;
         age <= 4'h0;
      end else begin
         cfg <= wr_cfg ? asp_cfg_s'(next_cfg) : cfg;
         age <= wr_cfg ? 4'h0 : (age == 4'hF ? age : age + 4'h1);
      end
   end
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!reset_n_in);
   a_reset_quiet: assert property (disable iff (1'b0)
      !reset_n_in |=> pins_out == '0 && avs_waitrequest_out && avs_readdata_out == '0)
      else $error("outputs not quiet after reset");
   a_bus_answer: assert property (
      (avs_read_in || avs_write_in) && avs_waitrequest_out && avs_address_in != ASP_TXDATA_OFS
      |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
      else $error("bus answer not a single cycle after the request");
   a_read_setup: assert property (
      done && avs_read_in && avs_address_in == ASP_SETUP_OFS |-> avs_readdata_out == {18'h0, cfg})
      else $error("setup readback differs from written value");
   a_read_unmapped: assert property (
      done && avs_read_in && !mapped |-> avs_readdata_out == 32'h0)
      else $error("unmapped read not zero");
   a_txd_float: assert property (
      age == 4'hF && !cfg.ena_tx |-> !pins_out.txd_oe)
      else $error("transmit data driven while path disabled");
   a_sync_pads: assert property (
      age == 4'hF |-> pins_out.fs_x_oe == cfg.fsx_src && pins_out.fs_r_oe == cfg.fsr_src)
      else $error("sync pad enable does not follow source bit");
   a_clock_pads: assert property (
      age == 4'hF |-> pins_out.bclk_x_oe == cfg.clkx_src && pins_out.bclk_r_oe == cfg.clkr_src)
      else $error("bit clock pad enable does not follow source bit");
   a_clock_runs: assert property (
      age == 4'hF && cfg.clkx_src |-> ##[1:16] !$stable(pins_out.bclk_x))
      else $error("generated bit clock not running");
endmodule

// *** asp_codec_model.sv ***
// behavioural codec: bit clock, frame sync and data of one serial frame
`timescale 1ns/1ps
module asp_codec_model (
   // serial data from the port
   input  wire logic   txd_in,
   // lines driven by the codec
   output logic        bclk_out,
   output logic        fs_out,
   output logic        rxd_out,
   // bits seen on the data line during the last frame
   output logic [31:0] heard_out
);
   // lines idle until a frame is sent
   initial begin
      bclk_out = 1'b0;
      fs_out = 1'b0;
      rxd_out = 1'b0;
      heard_out = 32'h0;
   end
   // 32 bit frame at 80 ns per bit; the clock stands low between frames
   task automatic send_frame(input logic [15:0] w);
      #3;
      for (int k = 0; k <= 32; k++) begin
         bclk_out = 1'b0;
         fs_out = k < 16;
         rxd_out = k < 16 ? w[15 - k] : ~rxd_out;
         #40;
         if (k > 0) begin
            heard_out[32 - k] = txd_in;
         end
         bclk_out = 1'b1;
         #40;
      end
      bclk_out = 1'b0;
   endtask
endmodule

// *** asp_tb.sv ***
// self-checking bench for the audio serial port setup block
`timescale 1ns/1ps
`define CHECK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
   $display("BAD %s expected %0h seen %0h", nm, e, g); end end
module testbench
   import asp_pkg::*;
;
   typedef struct packed {logic [13:0] cfg; logic [1:0] x; logic [1:0] r;} asp_row_s;
   // setup value, expected class of transmit and receive sync high time
   localparam asp_row_s ROWS [4] = '{'{14'h00F1, 2'h0, 2'h0}, '{14'h08F1, 2'h2, 2'h0},
                                     '{14'h04F1, 2'h0, 2'h2}, '{14'h00F0, 2'h1, 2'h1}};
   logic         core_clk_in, reset_n_in, avs_read_in, avs_write_in;
   logic [7:0]   avs_address_in;
   logic [31:0]  avs_writedata_in, rd, heard;
   logic [3:0]   avs_byteenable_in;
   logic [31:0]  avs_readdata_out;
   logic         avs_waitrequest_out, bclk, fs, rxd;
   asp_pin_in_s  pins_in;
   asp_pin_out_s pins_out;
   int           n_errors, comparisons;
   integer       hi_x, hi_r, hi_b; // four-state so an unknown pin level cannot pass
   // wire levels: a driving pad wins, a floating data line is pulled up
   wire logic txd_w = pins_out.txd_oe ? pins_out.txd : 1'b1;
   assign pins_in = {pins_out.bclk_x_oe ? pins_out.bclk_x : bclk,
                     pins_out.bclk_r_oe ? pins_out.bclk_r : bclk,
                     pins_out.fs_x_oe ? pins_out.fs_x : fs,
                     pins_out.fs_r_oe ? pins_out.fs_r : fs, rxd};
   asp_setup dut (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
      .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
      .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
      .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
      .pins_in(pins_in), .pins_out(pins_out));
   asp_codec_model codec (.txd_in(txd_w), .bclk_out(bclk), .fs_out(fs), .rxd_out(rxd),
      .heard_out(heard));
   // free running core clock
   initial begin
      core_clk_in = 1'b0;
      forever #4 core_clk_in = ~core_clk_in;
   end
   // one avalon access, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk_in);
      avs_read_in <= !w;
      avs_write_in <= w;
      avs_address_in <= a;
      avs_writedata_in <= d;
      do begin
         @(posedge core_clk_in);
         n++;
      end while (avs_waitrequest_out !== 1'b0 && n < 2000);
      rd = avs_readdata_out;
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
      `CHECK("bus answer", 1'b1, n < 2000)
   endtask
   // sync high-time class over two frames
   function automatic logic [1:0] cls(integer n);
      return n < 64 ? 2'h0 : (n > 448 ? 2'h2 : 2'h1);
   endfunction
   // verdict and end of run
   task automatic print_verdict();
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // watchdog
   initial begin
      #400_000;
      n_errors++;
      print_verdict();
   end
   // main sequence
   initial begin
      reset_n_in = 1'b0;
      avs_read_in = 1'b0;
      avs_write_in = 1'b0;
      avs_address_in = 8'h00;
      avs_writedata_in = 32'h0;
      avs_byteenable_in = 4'hF;
      repeat (8) @(posedge core_clk_in);
      reset_n_in <= 1'b1;
      bus(1'b0, ASP_SETUP_OFS, 32'h0);
      `CHECK("setup reset", 32'h0, rd)
      bus(1'b1, 8'h40, 32'hFFFF_FFFF);
      bus(1'b0, 8'h40, 32'h0);
      `CHECK("unmapped", 32'h0, rd)
      bus(1'b1, ASP_CLKDIV_OFS, 32'h0004_0004);
      bus(1'b1, ASP_FRAME_OFS, 32'h20);
      foreach (ROWS[i]) begin
         bus(1'b1, ASP_SETUP_OFS, {18'h0, ROWS[i].cfg});
         bus(1'b0, ASP_SETUP_OFS, 32'h0);
         `CHECK("setup readback", {18'h0, ROWS[i].cfg}, rd)
         repeat (64) @(posedge core_clk_in);
         hi_x = 0;
         hi_r = 0;
         hi_b = 0;
         repeat (512) begin
            @(posedge core_clk_in);
            hi_x += pins_out.fs_x;
            hi_r += pins_out.fs_r;
            hi_b += pins_out.bclk_x;
            hi_b += pins_out.bclk_r;
         end
         `CHECK("tx sync", ROWS[i].x, cls(hi_x))
         `CHECK("rx sync", ROWS[i].r, cls(hi_r))
         `CHECK("bit clocks", 512, hi_b)
      end
      bus(1'b1, ASP_SETUP_OFS, 32'h0);
      codec.send_frame(16'h1234);
      bus(1'b0, ASP_STATUS_OFS, 32'h0);
      `CHECK("rx while off", 4'h0, rd[11:8])
      bus(1'b1, ASP_TXDATA_OFS, 32'hBEEF);
      bus(1'b1, ASP_TXDATA_OFS, 32'h0F0F);
      bus(1'b0, ASP_STATUS_OFS, 32'h0);
      `CHECK("tx level", 4'h2, rd[3:0])
      bus(1'b1, ASP_SETUP_OFS, 32'h0C);
      codec.send_frame(16'hA55A);
      `CHECK("tx word0", 16'hBEEF, heard[31:16])
      codec.send_frame(16'h5AA5);
      `CHECK("tx word1", 16'h0F0F, heard[31:16])
      bus(1'b0, ASP_RXDATA_OFS, 32'h0);
      `CHECK("rx word0", 16'hA55A, rd[15:0])
      bus(1'b0, ASP_RXDATA_OFS, 32'h0);
      `CHECK("rx word1", 16'h5AA5, rd[15:0])
      bus(1'b0, ASP_RXDATA_OFS, 32'h0);
      `CHECK("rx empty", 32'h0, rd)
      bus(1'b1, ASP_TXDATA_OFS, 32'h1111);
      bus(1'b1, ASP_TXDATA_OFS, 32'h2222);
      bus(1'b1, ASP_SETUP_OFS, 32'h0E);
      codec.send_frame(16'h0000);
      `CHECK("stereo frame", 32'h1111_2222, heard)
      repeat (8) codec.send_frame(16'hC3C3);
      bus(1'b0, ASP_STATUS_OFS, 32'h0);
      `CHECK("rx full", 4'h8, rd[11:8])
      `CHECK("overrun", 1'b1, rd[16])
      bus(1'b1, ASP_STATUS_OFS, 32'h0001_0000);
      bus(1'b0, ASP_STATUS_OFS, 32'h0);
      `CHECK("overrun clear", 1'b0, rd[16])
      // inverted external sync: the word starts where the codec sync falls
      bus(1'b1, ASP_TXDATA_OFS, 32'h6C93);
      bus(1'b1, ASP_SETUP_OFS, 32'h808);
      codec.send_frame(16'h0000);
      `CHECK("inverted sync", 32'h0000_6C93, heard)
      // falling transmit edge: each bit moves half a bit period earlier
      bus(1'b1, ASP_TXDATA_OFS, 32'h35A1);
      bus(1'b1, ASP_SETUP_OFS, 32'hA08);
      codec.send_frame(16'h0000);
      `CHECK("falling edge", 32'h0000_6B42, heard)
      // reset in mid-run clears the setup register again
      reset_n_in <= 1'b0;
      repeat (2) @(posedge core_clk_in);
      reset_n_in <= 1'b1;
      bus(1'b0, ASP_SETUP_OFS, 32'h0);
      `CHECK("setup after reset", 32'h0, rd)
      print_verdict();
   end
endmodule
bind asp_setup asp_sva chk (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
   .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
   .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
   .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
   .pins_in(pins_in), .pins_out(pins_out));
